// [dv/adc_result_postprocessor_test.sv]
/*
 Self-checking bench of the result post-processor: registers, filter, comparator.
 Assumes the conversion core model and the register offsets of the design header.
*/
`timescale 1ns/10ps
`include "adc_pp_consts.svh"
module adc_result_postprocessor_test;
    logic        clock = 1'b0;  // 100 MHz
    logic        rst = 1'b1;    // Async reset
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic        conv_valid;
    logic [4:0]  conv_chan;
    logic [11:0] conv_data;
    logic        filter_irq;
    logic        common_irq;
    logic        irq;
    int          err_total = 0;
    int          n_checks = 0;
    int          n_firq = 0;
    int          n_cirq = 0;

    adc_result_postprocessor #(.SAMPLE_W(12)) i_adc_result_postprocessor (
        .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .conv_valid(conv_valid), .conv_chan(conv_chan), .conv_data(conv_data),
        .filter_irq(filter_irq), .common_irq(common_irq), .irq(irq));
    conv_core_model #(.SAMPLE_W(12)) i_conv_core_model (
        .clock(clock), .conv_valid(conv_valid), .conv_chan(conv_chan), .conv_data(conv_data));

    // Clock
    always #5 clock = ~clock;
    // Pulse counters, so a one-cycle pulse is never missed by polling
    always @(posedge clock) begin
        if (filter_irq === 1'b1) n_firq <= n_firq + 1;
        if (common_irq === 1'b1) n_cirq <= n_cirq + 1;
    end

    task automatic end_sim;
        if (err_total == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk16(input string name, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe: sample mid-cycle
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        d = reg_rdata;
    endtask
    function automatic logic [15:0] ctl(logic on, logic [1:0] m, logic [2:0] r, logic ie, logic [4:0] s);
        return {on, m, r, ie, 4'h0, s};
    endfunction

    // Reset values, read-only upper mask bits, unmapped index
    task automatic reset_case;
        logic [15:0] d;
        for (int a = 0; a < 3; a++) begin
            rd(4'(a), d);
            chk16("reset_reg", `RESET_VALUE, d);
        end
        chk16("irq_reset", 16'h0000, {15'h0, irq});
        wr(`OFS_MASK_HIGH, 16'hffff);
        rd(`OFS_MASK_HIGH, d);
        chk16("mask_high", 16'h0003, d);
        wr(`OFS_MASK_LOW, 16'hffff);
        rd(`OFS_MASK_LOW, d);
        chk16("mask_low", 16'hffff, d);
        wr(4'hf, 16'hffff);
        rd(4'hf, d);
        chk16("unmapped", 16'h0000, d);
    endtask

    // One filter result: count exactness, ignored channel, ready, irq, scaling
    task automatic filt_case(input logic [1:0] m, input logic [2:0] r, input logic [4:0] s,
                             input int n, input logic [15:0] e);
        logic [15:0] d;
        int f0;
        int c0;
        wr(`OFS_FILT_CTRL, ctl(1'b1, m, r, 1'b1, s));
        f0 = n_firq;
        c0 = n_cirq;
        repeat (n - 1) i_conv_core_model.send(s, 12'hfff);
        i_conv_core_model.send(s ^ 5'h01, 12'h000);
        rd(`OFS_FILT_CTRL, d);
        chk16("ready_early", 16'h0000, d & 16'h0100);
        i_conv_core_model.send(s, 12'hfff);
        rd(`OFS_FILT_CTRL, d);
        chk16("ctrl_ready", ctl(1'b1, m, r, 1'b1, s) | 16'h0100, d);
        rd(`OFS_FILT_RESULT, d);
        chk16("result", e, d);
        rd(`OFS_FILT_CTRL, d);
        chk16("ready_cleared", 16'h0000, d & 16'h0100);
        chk16("filter_irq", 16'(f0 + 1), 16'(n_firq));
        chk16("common_irq", 16'(c0 + 1), 16'(n_cirq));
        wr(`OFS_FILT_CTRL, 16'h0000);
    endtask

    // Both working modes and every ratio code, channels 2..17 including the internal ones
    task automatic ratio_case;
        logic [2:0] r;
        for (int i = 0; i < 16; i++) begin
            r = 3'(i);
            if (i < 8) filt_case(2'b00, r, 5'(i + 2), r[2] ? (2 << (2 * r[1:0])) : (4 << (2 * r[1:0])),
                                 16'h0fff << (r[1:0] + 1));
            else filt_case(2'b11, r, 5'(i + 2), 2 << r, 16'h0fff);
        end
    endtask

    // Irq enable off, control read-back after disable, reserved modes stay idle
    task automatic ctrl_case;
        logic [15:0] d;
        int f0;
        int c0;
        f0 = n_firq;
        c0 = n_cirq;
        wr(`OFS_FILT_CTRL, ctl(1'b1, 2'b00, 3'b100, 1'b0, 5'h04));
        repeat (2) i_conv_core_model.send(5'h04, 12'h123);
        rd(`OFS_FILT_CTRL, d);
        chk16("ready_no_ie", 16'h0100, d & 16'h0100);
        chk16("no_filter_irq", 16'(f0), 16'(n_firq));
        chk16("no_common_irq", 16'(c0), 16'(n_cirq));
        rd(`OFS_FILT_RESULT, d);
        chk16("sum_2x", 16'h0246, d);
        // Second result must not carry the first sum
        repeat (2) i_conv_core_model.send(5'h04, 12'h001);
        rd(`OFS_FILT_RESULT, d);
        chk16("restart", 16'h0002, d);
        wr(`OFS_FILT_CTRL, ctl(1'b0, 2'b00, 3'b100, 1'b0, 5'h04));
        rd(`OFS_FILT_CTRL, d);
        chk16("off_ready", 16'h1004, d);
        for (int m = 1; m < 3; m++) begin
            wr(`OFS_FILT_CTRL, ctl(1'b1, 2'(m), 3'b100, 1'b1, 5'h04));
            repeat (4) i_conv_core_model.send(5'h04, 12'h123);
            rd(`OFS_FILT_CTRL, d);
            chk16("rsvd_ready", 16'h0000, d & 16'h0100);
        end
        wr(`OFS_FILT_CTRL, ctl(1'b1, 2'b00, 3'b100, 1'b1, 5'h12));
        repeat (2) i_conv_core_model.send(5'h12, 12'h123);
        rd(`OFS_FILT_CTRL, d);
        chk16("rsvd_select", 16'h0000, d & 16'h0100);
        wr(`OFS_FILT_CTRL, 16'h0000);
    endtask

    // Between-window events, channel masking, channel capture, status irq
    task automatic cmp_case;
        logic [15:0] d;
        int c0;
        wr(`OFS_CMP_LOW, 16'h0100);
        wr(`OFS_CMP_HIGH, 16'h0200);
        wr(`OFS_MASK_LOW, 16'h0020);
        wr(`OFS_MASK_HIGH, 16'h0001);
        wr(`OFS_CMP_CTRL, 16'h00d0);
        wr(`OFS_IRQ_MASK, 16'h0002);
        rd(`OFS_IRQ_STATUS, d);
        c0 = n_cirq;
        i_conv_core_model.send(5'h05, 12'h100);
        @(negedge clock);
        chk16("irq_level", 16'h0001, {15'h0, irq});
        rd(`OFS_CMP_CTRL, d);
        chk16("cmp_event", 16'h05f0, d);
        rd(`OFS_IRQ_STATUS, d);
        chk16("status", 16'h0002, d & 16'h0002);
        chk16("irq_clear", 16'h0000, {15'h0, irq});
        chk16("cmp_common", 16'(c0 + 1), 16'(n_cirq));
        i_conv_core_model.send(5'h05, 12'h0ff);
        i_conv_core_model.send(5'h05, 12'h200);
        i_conv_core_model.send(5'h06, 12'h150);
        rd(`OFS_CMP_CTRL, d);
        chk16("no_event", 16'h0000, d & 16'h0020);
        i_conv_core_model.send(5'h10, 12'h1ff);
        rd(`OFS_CMP_CTRL, d);
        chk16("event_ch16", 16'h10f0, d);
        // Single-sided conditions: a miss, then a hit on channel 5
        for (int k = 0; k < 4; k++) begin
            wr(`OFS_CMP_CTRL, 16'h0080 | (16'h0001 << k));
            i_conv_core_model.send(5'h05, k[0] ? 12'h0ff : 12'h200);
            rd(`OFS_CMP_CTRL, d);
            chk16("cond_miss", 16'h0000, d & 16'h0020);
            i_conv_core_model.send(5'h05, k[0] ? 12'h200 : 12'h0ff);
            rd(`OFS_CMP_CTRL, d);
            chk16("cond_hit", 16'h05a0 | (16'h0001 << k), d);
        end
        // Restore the window and clear status so the sticky check sees one event
        wr(`OFS_CMP_CTRL, 16'h00d0);
        rd(`OFS_IRQ_STATUS, d);
        wr(`OFS_IRQ_MASK, 16'h0000);
        i_conv_core_model.send(5'h10, 12'h150);
        @(negedge clock);
        chk16("irq_masked", 16'h0000, {15'h0, irq});
        rd(`OFS_IRQ_STATUS, d);
        chk16("status_sticky", 16'h0002, d & 16'h0002);
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        reset_case();
        ratio_case();
        ctrl_case();
        cmp_case();
        end_sim();
    end
    // Watchdog: the tests take about 2500 cycles
    initial begin
        repeat (50000) @(posedge clock);
        err_total++;
        end_sim();
    end
endmodule

// [dv/conv_core_model.sv]
/*
 Behavioural model of the conversion core feeding the post-processor.
 Assumes one clock shared with the block; results are sent one per call.
*/
`timescale 1ns/10ps
module conv_core_model #(
    parameter int SAMPLE_W = 12
) (
    input  wire logic           clock,      // Core clock
    output logic                conv_valid, // Result strobe
    output logic [4:0]          conv_chan,  // Channel number
    output logic [SAMPLE_W-1:0] conv_data   // Result value
);
    // Idle state at time zero
    initial begin
        conv_valid = 1'b0;
        conv_chan  = 5'h1f;
        conv_data  = '0;
    end
    // One result per call; idle lines inverted so stale values never look valid
    task automatic send(input logic [4:0] ch, input logic [SAMPLE_W-1:0] d);
        @(posedge clock);
        conv_valid <= 1'b1;
        conv_chan  <= ch;
        conv_data  <= d;
        @(posedge clock);
        conv_valid <= 1'b0;
        conv_chan  <= ~ch;
        conv_data  <= ~d;
    endtask
endmodule

// [rtl/adc_pp_consts.svh]
/*
 Offsets, field positions, reset values and counts of the result post-processor.
 Assumes inclusion by bare name from design files of the block.
*/
`ifndef ADC_PP_CONSTS_SVH
`define ADC_PP_CONSTS_SVH
// Register offsets on the plain register port
`define OFS_MASK_LOW      4'h0
`define OFS_MASK_HIGH     4'h1
`define OFS_FILT_CTRL     4'h2
`define OFS_FILT_RESULT   4'h3
`define OFS_CMP_CTRL      4'h4
`define OFS_CMP_LOW       4'h5
`define OFS_CMP_HIGH      4'h6
`define OFS_IRQ_STATUS    4'h7
`define OFS_IRQ_MASK      4'h8
// Filter control fields
`define FC_ON_BIT         15
`define FC_MODE_HI        14
`define FC_MODE_LO        13
`define FC_RATIO_HI       12
`define FC_RATIO_LO       10
`define FC_IRQ_BIT        9
`define FC_RDY_BIT        8
`define FC_SEL_HI         4
`define FC_SEL_LO         0
`define FC_WRITE_MASK     16'hfe1f
// Comparator control fields
`define CC_CHAN_HI        12
`define CC_CHAN_LO        8
`define CC_ON_BIT         7
`define CC_IRQ_BIT        6
`define CC_STAT_BIT       5
`define CC_BTWN_BIT       4
`define CC_HIHI_BIT       3
`define CC_HILO_BIT       2
`define CC_LOHI_BIT       1
`define CC_LOLO_BIT       0
`define CC_WRITE_MASK     16'h00df
// Status bits
`define ST_FILT_BIT       0
`define ST_CMP_BIT        1
`define HIGH_MASK_BITS    16'h0003
`define RESET_VALUE       16'h0000
`define LAST_CHANNEL      5'h11
`endif

// [rtl/adc_pp_pkg.sv]
/*
 Types of the result post-processor.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package adc_pp_pkg;
    typedef enum logic [1:0] {
        MODE_OVERSAMPLE = 2'b00,
        MODE_RSVD1      = 2'b01,
        MODE_RSVD2      = 2'b10,
        MODE_AVERAGE    = 2'b11
    } filter_mode_t;
endpackage

// [rtl/adc_result_postprocessor.sv]
/*
 Comparator channel mask, digital comparator and oversampling/averaging filter.
 Assumes the conversion core presents one result with its channel number per
 valid cycle, synchronous to clock.
*/
// Design decisions made here: the strobed register port and the register offsets.
// Behaviour
// - mask bits 15..0 route channels to comparator
// - high mask holds channels 16,17; rest zero
// - filter runs only when on; off clears ready
// - ratios 0-3 oversample 4..256, 13..16 bits
// - ratios 4-7 oversample 2..128, 13..16 bits
// - averaging yields 12 bits, 2..256 samples
// - filter irq enable raises both interrupts
// - ready sets on result, clears on read
// - five-bit select picks filter input channel
// - between-window event when low<=x<high
// - event records channel and sets status
`timescale 1ns/10ps
`include "adc_pp_consts.svh"
module adc_result_postprocessor #(
    parameter int SAMPLE_W = 12
) (
    input  wire logic                clock,       // 100 MHz clock
    input  wire logic                rst,         // Async reset, high
    input  wire logic [3:0]          reg_addr,    // Register index
    input  wire logic [15:0]         reg_wdata,   // Write data
    input  wire logic                reg_wr,      // Write strobe
    input  wire logic                reg_rd,      // Read strobe
    output logic [15:0]              reg_rdata,   // Read data, next cycle
    input  wire logic                conv_valid,  // Conversion done
    input  wire logic [4:0]          conv_chan,   // Converted channel
    input  wire logic [SAMPLE_W-1:0] conv_data,   // Conversion result
    output logic                     filter_irq,  // Filter interrupt
    output logic                     common_irq,  // Common ADC interrupt
    output logic                     irq          // Masked status interrupt
);
    initial begin
        if (SAMPLE_W != 12) $error("adc_result_postprocessor needs SAMPLE_W 12");
    end

    logic [15:0] mask_low_r;
    logic [1:0]  mask_high_r;
    logic [15:0] fctrl_r;
    logic        rdy_r;
    logic [15:0] cctrl_r;
    logic [4:0]  event_chan_r;
    logic        cmp_stat_r;
    logic [11:0] cmp_low_r;
    logic [11:0] cmp_high_r;
    logic [1:0]  status_r;
    logic [1:0]  irq_mask_r;
    logic [15:0] rdata_r;
    logic        filt_irq_r;
    logic        cmp_irq_r;

    logic [17:0]                 chan_enable;
    logic                        filter_on;
    adc_pp_pkg::filter_mode_t    mode;
    logic [2:0]                  ratio;
    logic                        run;
    logic                        filt_sample;
    logic [3:0]                  log_count;
    logic [3:0]                  shift;
    logic                        filt_done;
    logic [15:0]                 filt_result;
    logic                        cmp_hit;
    logic                        rd_result;
    logic                        rd_cctrl;
    logic                        rd_status;
    logic [1:0]                  events;

    // Decoded control fields
    assign filter_on   = fctrl_r[`FC_ON_BIT];
    assign mode        = adc_pp_pkg::filter_mode_t'(fctrl_r[`FC_MODE_HI:`FC_MODE_LO]);
    assign ratio       = fctrl_r[`FC_RATIO_HI:`FC_RATIO_LO];
    assign chan_enable = {mask_high_r, mask_low_r};
    assign rd_result   = reg_rd && (reg_addr == `OFS_FILT_RESULT);
    assign rd_cctrl    = reg_rd && (reg_addr == `OFS_CMP_CTRL);
    assign rd_status   = reg_rd && (reg_addr == `OFS_IRQ_STATUS);

    // Reserved modes hold the filter idle rather than guess a behaviour
    assign run = filter_on && (mode == adc_pp_pkg::MODE_OVERSAMPLE
                 || mode == adc_pp_pkg::MODE_AVERAGE);
    // Reserved select codes above the band-gap never match a channel
    assign filt_sample = conv_valid && (conv_chan == fctrl_r[`FC_SEL_HI:`FC_SEL_LO])
                         && (conv_chan <= `LAST_CHANNEL);

    // Sample count and scaling per mode and ratio
    always_comb begin
        log_count = 4'h1;
        shift     = 4'h0;
        if (mode == adc_pp_pkg::MODE_AVERAGE) begin
            log_count = {1'b0, ratio} + 4'h1;
            shift     = log_count;
        end else if (ratio[2]) begin
            log_count = {1'b0, ratio[1:0], 1'b1};
            shift     = {2'b00, ratio[1:0]};
        end else begin
            log_count = {1'b0, ratio[1:0], 1'b0} + 4'h2;
            shift     = {2'b00, ratio[1:0]} + 4'h1;
        end
    end

    sample_accumulator #(
        .SAMPLE_W (SAMPLE_W)
    ) u_acc (
        .clock     (clock),
        .rst       (rst),
        .run       (run),
        .sample_en (filt_sample),
        .sample    (conv_data),
        .log_count (log_count),
        .shift     (shift),
        .done      (filt_done),
        .result_r  (filt_result)
    );

    // Comparator condition for an enabled channel
    always_comb begin
        logic [11:0] x;
        logic        lo;
        logic        hi;
        x  = conv_data;
        lo = x < cmp_low_r;
        hi = x >= cmp_high_r;
        cmp_hit = conv_valid && cctrl_r[`CC_ON_BIT] && (conv_chan <= `LAST_CHANNEL)
                  && chan_enable[conv_chan]
                  && ((cctrl_r[`CC_BTWN_BIT] && !lo && !hi)
                   || (cctrl_r[`CC_HIHI_BIT] && hi)
                   || (cctrl_r[`CC_HILO_BIT] && !hi)
                   || (cctrl_r[`CC_LOHI_BIT] && !lo)
                   || (cctrl_r[`CC_LOLO_BIT] && lo));
    end

    // Mask registers; only two high bits exist
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mask_low_r  <= `RESET_VALUE;
            mask_high_r <= 2'h0;
        end else if (reg_wr && reg_addr == `OFS_MASK_LOW) begin
            mask_low_r <= reg_wdata;
        end else if (reg_wr && reg_addr == `OFS_MASK_HIGH) begin
            mask_high_r <= reg_wdata[1:0];
        end
    end

    // Filter and comparator control plus thresholds
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fctrl_r    <= `RESET_VALUE;
            cctrl_r    <= `RESET_VALUE;
            cmp_low_r  <= 12'h000;
            cmp_high_r <= 12'h000;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `OFS_FILT_CTRL: fctrl_r <= reg_wdata & `FC_WRITE_MASK;
                `OFS_CMP_CTRL:  cctrl_r <= reg_wdata & `CC_WRITE_MASK;
                `OFS_CMP_LOW:   cmp_low_r <= reg_wdata[11:0];
                `OFS_CMP_HIGH:  cmp_high_r <= reg_wdata[11:0];
                default: ;
            endcase
        end
    end

    // Ready flag: a new result wins over a read in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdy_r <= 1'b0;
        end else if (!filter_on) begin
            rdy_r <= 1'b0;
        end else if (filt_done) begin
            rdy_r <= 1'b1;
        end else if (rd_result) begin
            rdy_r <= 1'b0;
        end
    end

    // Comparator event channel and status; a read of control clears status
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            event_chan_r <= 5'h00;
            cmp_stat_r   <= 1'b0;
        end else if (!cctrl_r[`CC_ON_BIT]) begin
            cmp_stat_r <= 1'b0;
        end else if (cmp_hit) begin
            event_chan_r <= conv_chan;
            cmp_stat_r   <= 1'b1;
        end else if (rd_cctrl) begin
            cmp_stat_r <= 1'b0;
        end
    end

    // Interrupt pulses registered for clean outputs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            filt_irq_r <= 1'b0;
            cmp_irq_r  <= 1'b0;
        end else begin
            filt_irq_r <= filt_done && fctrl_r[`FC_IRQ_BIT];
            cmp_irq_r  <= cmp_hit && cctrl_r[`CC_IRQ_BIT];
        end
    end
    assign filter_irq = filt_irq_r;
    assign common_irq = filt_irq_r || cmp_irq_r;

    // Sticky status; event beats the clearing read
    assign events = {cmp_hit, filt_done};
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            status_r <= 2'h0;
        end else begin
            status_r <= (rd_status ? 2'h0 : status_r) | events;
        end
    end

    // Interrupt mask
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_mask_r <= 2'h0;
        end else if (reg_wr && reg_addr == `OFS_IRQ_MASK) begin
            irq_mask_r <= reg_wdata[1:0];
        end
    end
    assign irq = |(status_r & irq_mask_r);

    // Read data register; unmapped addresses read zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_r <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `OFS_MASK_LOW:    rdata_r <= mask_low_r;
                `OFS_MASK_HIGH:   rdata_r <= {14'h0000, mask_high_r};
                `OFS_FILT_CTRL:   rdata_r <= fctrl_r | ({15'h0000, rdy_r} << `FC_RDY_BIT);
                `OFS_FILT_RESULT: rdata_r <= filt_result;
                `OFS_CMP_CTRL:    rdata_r <= cctrl_r | {3'h0, event_chan_r, 2'h0, cmp_stat_r, 5'h00};
                `OFS_CMP_LOW:     rdata_r <= {4'h0, cmp_low_r};
                `OFS_CMP_HIGH:    rdata_r <= {4'h0, cmp_high_r};
                `OFS_IRQ_STATUS:  rdata_r <= {14'h0000, status_r};
                `OFS_IRQ_MASK:    rdata_r <= {14'h0000, irq_mask_r};
                default:          rdata_r <= 16'h0000;
            endcase
        end else begin
            rdata_r <= 16'h0000;
        end
    end
    assign reg_rdata = rdata_r;

    // Checks
    property p_mask_gate;
        @(posedge clock) disable iff (rst)
        (conv_valid && conv_chan <= `LAST_CHANNEL && !chan_enable[conv_chan]) |-> !cmp_hit;
    endproperty
    a_mask_gate: assert property (p_mask_gate) else $error("masked channel hit comparator");

    property p_high_zero;
        @(posedge clock) disable iff (rst)
        (reg_rd && reg_addr == `OFS_MASK_HIGH) |=> (reg_rdata[15:2] == 14'h0000);
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("high mask upper bits not zero");

    property p_off_clears;
        @(posedge clock) disable iff (rst)
        !filter_on |=> !rdy_r;
    endproperty
    a_off_clears: assert property (p_off_clears) else $error("ready set while filter off");

    property p_reserved_idle;
        @(posedge clock) disable iff (rst)
        (mode == adc_pp_pkg::MODE_RSVD1 || mode == adc_pp_pkg::MODE_RSVD2) |-> !filt_done;
    endproperty
    a_reserved_idle: assert property (p_reserved_idle) else $error("reserved mode produced result");

    property p_ovs_width;
        @(posedge clock) disable iff (rst)
        (filt_done && mode == adc_pp_pkg::MODE_OVERSAMPLE && ratio[1:0] == 2'b00) |=> (filt_result[15:13] == 3'h0);
    endproperty
    a_ovs_width: assert property (p_ovs_width) else $error("13-bit result too wide");

    property p_avg_width;
        @(posedge clock) disable iff (rst)
        (filt_done && mode == adc_pp_pkg::MODE_AVERAGE) |=> (filt_result[15:12] == 4'h0);
    endproperty
    a_avg_width: assert property (p_avg_width) else $error("average wider than 12 bits");

    property p_irq_follow;
        @(posedge clock) disable iff (rst)
        filt_done |=> (filter_irq == $past(fctrl_r[`FC_IRQ_BIT])) && (common_irq || !filter_irq);
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("filter irq mismatch");

    property p_rdy_set;
        @(posedge clock) disable iff (rst)
        (filt_done && filter_on) |=> rdy_r;
    endproperty
    a_rdy_set: assert property (p_rdy_set) else $error("ready not set on result");

    property p_event_chan;
        @(posedge clock) disable iff (rst)
        cmp_hit |=> (cmp_stat_r && event_chan_r == $past(conv_chan));
    endproperty
    a_event_chan: assert property (p_event_chan) else $error("event channel not recorded");

    property p_rdy_clear;
        @(posedge clock) disable iff (rst)
        (rd_result && !filt_done) |=> !rdy_r;
    endproperty
    a_rdy_clear: assert property (p_rdy_clear) else $error("ready kept after result read");

    property p_run_only;
        @(posedge clock) disable iff (rst)
        !filter_on |-> !filt_done;
    endproperty
    a_run_only: assert property (p_run_only) else $error("result while filter off");

    property p_btwn_hit;
        @(posedge clock) disable iff (rst)
        (conv_valid && cctrl_r[`CC_ON_BIT] && cctrl_r[`CC_BTWN_BIT] && conv_chan <= `LAST_CHANNEL
         && chan_enable[conv_chan] && conv_data >= cmp_low_r && conv_data < cmp_high_r) |-> cmp_hit;
    endproperty
    a_btwn_hit: assert property (p_btwn_hit) else $error("window event missed");

    property p_no_ie;
        @(posedge clock) disable iff (rst)
        (filt_done && !fctrl_r[`FC_IRQ_BIT]) |=> !filter_irq;
    endproperty
    a_no_ie: assert property (p_no_ie) else $error("filter irq while disabled");

    // No disable here: this one watches the reset itself
    property p_reset_zero;
        @(posedge clock)
        rst |=> (fctrl_r == `RESET_VALUE && cctrl_r == `RESET_VALUE && mask_low_r == `RESET_VALUE
                 && mask_high_r == 2'h0 && irq_mask_r == 2'h0);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("register not zero after reset");

    property p_ovs_w14;
        @(posedge clock) disable iff (rst)
        (filt_done && mode == adc_pp_pkg::MODE_OVERSAMPLE && ratio[1:0] == 2'b01)
        |=> (filt_result[15:14] == 2'h0);
    endproperty
    a_ovs_w14: assert property (p_ovs_w14) else $error("14-bit result too wide");

    property p_ovs_w15;
        @(posedge clock) disable iff (rst)
        (filt_done && mode == adc_pp_pkg::MODE_OVERSAMPLE && ratio[1:0] == 2'b10) |=> !filt_result[15];
    endproperty
    a_ovs_w15: assert property (p_ovs_w15) else $error("15-bit result too wide");

    property p_result_hold;
        @(posedge clock) disable iff (rst)
        !filt_done |=> $stable(filt_result);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result changed without new sum");

    property p_sel_range;
        @(posedge clock) disable iff (rst)
        (conv_valid && conv_chan > `LAST_CHANNEL) |-> (!filt_done && !cmp_hit);
    endproperty
    a_sel_range: assert property (p_sel_range) else $error("reserved channel used");
endmodule

// [rtl/sample_accumulator.sv]
/*
 Accumulator that sums samples and yields the shifted result after a set count.
 Assumes one sample strobe at most per clock and a static ratio while running.
*/
`timescale 1ns/10ps
`include "adc_pp_consts.svh"
module sample_accumulator #(
    parameter int SAMPLE_W = 12
) (
    input  wire logic                clock,     // Core clock
    input  wire logic                rst,       // Async reset
    input  wire logic                run,       // Filter running
    input  wire logic                sample_en, // New sample
    input  wire logic [SAMPLE_W-1:0] sample,    // Sample value
    input  wire logic [3:0]          log_count, // Log2 of sample count
    input  wire logic [3:0]          shift,     // Right shift of sum
    output logic                     done,      // Result strobe
    output logic [15:0]              result_r   // Shifted result
);
    initial begin
        if (SAMPLE_W != 12) $error("sample_accumulator needs SAMPLE_W 12");
    end
    logic [SAMPLE_W+7:0] sum_r;
    logic [8:0]          cnt_r;
    logic [SAMPLE_W+7:0] sum_nxt;
    logic [8:0]          target;
    logic [SAMPLE_W+7:0] shifted;

    // Sum includes the sample of this cycle so no result is one sample late
    always_comb begin
        sum_nxt = sum_r + {8'h00, sample};
        target  = 9'h001 << log_count;
        shifted = sum_nxt >> shift;
        done    = run && sample_en && ((cnt_r + 9'h001) == target);
    end

    // Count and sum; restart after each published result
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sum_r <= '0;
            cnt_r <= 9'h000;
        end else if (!run || done) begin
            sum_r <= '0;
            cnt_r <= 9'h000;
        end else if (sample_en) begin
            sum_r <= sum_nxt;
            cnt_r <= cnt_r + 9'h001;
        end
    end

    // Result register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            result_r <= 16'h0000;
        end else if (done) begin
            result_r <= shifted[15:0];
        end
    end
endmodule
